/* File: include/scmf_pkg.sv */
// Package holding the message codes, service response codes and widths of the framer.
package scmf_pkg;
  localparam logic [7:0] SCMF_SMS_CODE     = 8'h83;
  localparam logic [7:0] SCMF_S3P_CMD_STAT = 8'h10;
  localparam logic [7:0] SCMF_SEND_CTRL    = 8'h00;
  localparam logic [7:0] SCMF_SMS_LEN      = 8'h20;
  localparam int         SCMF_TBL_DEPTH    = 16;
  localparam int         SCMF_TBL_AW       = 4;
  localparam logic [1:0] SCMF_RC_OK        = 2'h0;
  localparam logic [1:0] SCMF_RC_FAILED    = 2'h1;
  localparam logic [1:0] SCMF_RC_INVALID   = 2'h2;
  typedef enum logic [1:0] {
    SCMF_SR_TASK_COMPLETE = 2'h0,
    SCMF_SR_LINKED        = 2'h1,
    SCMF_SR_LINKED_FLAG   = 2'h2,
    SCMF_SR_DELIV_FAIL    = 2'h3
  } scmf_svc_resp_t;
endpackage

/* File: rtl/scmf_framer.sv */
// Protocol-layer framer for command, status and Data-In services.
// Requirements
// R1: Valid command message raises command indication.
// R2: Source ID looked up by return path.
// R3: Status message codes are 83h and 10h.
// R4: Status carries command tag and status value.
// R5: Service response encoded into FLAG, LINK bits.
// R6: Send status with control 00h, destination, length.
// R7: Initiator looks up table entry by status tag.
// R8: Status completion returns status, task complete.
// R9: Transport failures raise completion indication.
// R10: Failure completion uses tag, table lookup.
// R11: Failure completion reports delivery or target failure; the block always reports delivery failure.
// R12: Initiator supplies own unique ID as source.
// R13: Data-In request maps onto target read.
// R14: Default start equals byte count, threshold zero.
// R15: Target read failure produces failure completion.
// R16: Successful target read leads to data ready; the block raises no indication on success.
// R17: Data-Out uses target write, data request; this block has no Data-Out path.
// R18: Initiator builds commands with 83h and 10h; this block only receives commands.
// R19: Invalid message codes produce no indication.
`timescale 1ns/1ps
`default_nettype none
module scmf_framer
  import scmf_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic [63:0] i_own_uid,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_sms_code,
  input  wire logic [7:0]  i_rx_s3p_code,
  input  wire logic [15:0] i_rx_tag,
  input  wire logic [7:0]  i_rx_lun,
  input  wire logic [1:0]  i_rx_qcntl,
  input  wire logic [7:0]  i_rx_status,
  input  wire logic [7:0]  i_rx_rpid,
  input  wire logic [127:0] i_rx_cdb,
  input  wire logic        i_uid_ack,
  input  wire logic [63:0] i_uid_val,
  input  wire logic        i_cc_req,
  input  wire logic [63:0] i_cc_dest,
  input  wire logic [15:0] i_cc_tag,
  input  wire logic [7:0]  i_cc_status,
  input  wire logic [1:0]  i_cc_resp,
  input  wire logic        i_tbl_wr,
  input  wire logic [15:0] i_tbl_tag,
  input  wire logic [63:0] i_tbl_dest,
  input  wire logic [7:0]  i_tbl_lun,
  input  wire logic [31:0] i_tbl_dibuf,
  input  wire logic        i_fail_valid,
  input  wire logic [1:0]  i_fail_rc,
  input  wire logic [15:0] i_fail_tag,
  input  wire logic        i_di_req,
  input  wire logic [63:0] i_di_dest,
  input  wire logic [15:0] i_di_tag,
  input  wire logic [31:0] i_di_buf,
  input  wire logic [31:0] i_di_offset,
  input  wire logic [31:0] i_di_count,
  input  wire logic        i_tr_done,
  input  wire logic [1:0]  i_tr_rc,
  output logic             o_uid_req,
  output logic [7:0]       o_uid_rpid,
  output logic             o_cmd_ind,
  output logic [63:0]      o_cmd_src,
  output logic [15:0]      o_cmd_tag,
  output logic [7:0]       o_cmd_lun,
  output logic [1:0]       o_cmd_attr,
  output logic [127:0]     o_cmd_cdb,
  output logic             o_tx_send,
  output logic [7:0]       o_tx_ctrl,
  output logic [63:0]      o_tx_dest,
  output logic [7:0]       o_tx_len,
  output logic [7:0]       o_tx_sms_code,
  output logic [7:0]       o_tx_s3p_code,
  output logic [15:0]      o_tx_tag,
  output logic [7:0]       o_tx_status,
  output logic             o_tx_flag,
  output logic             o_tx_link,
  output logic             o_cpl_ind,
  output logic [63:0]      o_cpl_dest,
  output logic [63:0]      o_cpl_src,
  output logic [15:0]      o_cpl_tag,
  output logic [7:0]       o_cpl_lun,
  output logic [31:0]      o_cpl_dibuf,
  output logic [7:0]       o_cpl_status,
  output logic [1:0]       o_cpl_resp,
  output logic             o_tr_req,
  output logic [63:0]      o_tr_dest,
  output logic [15:0]      o_tr_tag,
  output logic [31:0]      o_tr_buf,
  output logic [31:0]      o_tr_offset,
  output logic [31:0]      o_tr_count,
  output logic [31:0]      o_tr_start,
  output logic [31:0]      o_tr_thresh,
  output logic             o_tc_ind,
  output logic [1:0]       o_tc_resp
);
  typedef enum logic [1:0] {
    SCMF_CMD_IDLE = 2'b01,
    SCMF_CMD_WAIT = 2'b10
  } scmf_cmd_st_t;

  scmf_cmd_st_t cmd_st_r;
  logic         codes_ok;
  logic         is_cmd;
  logic         is_stat;
  logic         fail_hit;
  logic [SCMF_TBL_AW-1:0] stat_idx;
  logic [SCMF_TBL_AW-1:0] fail_idx;
  logic [63:0]  tbl_dest_r  [SCMF_TBL_DEPTH];
  logic [7:0]   tbl_lun_r   [SCMF_TBL_DEPTH];
  logic [31:0]  tbl_dibuf_r [SCMF_TBL_DEPTH];

  // The same codes mark both command and status; a non-zero CDB marks a command.
  assign codes_ok = (i_rx_sms_code == SCMF_SMS_CODE) && (i_rx_s3p_code == SCMF_S3P_CMD_STAT);
  assign is_cmd   = i_rx_valid && codes_ok && (i_rx_cdb != 128'h0);  // see R19
  assign is_stat  = i_rx_valid && codes_ok && (i_rx_cdb == 128'h0);  // see R19
  assign fail_hit = i_fail_valid && (i_fail_rc == SCMF_RC_FAILED || i_fail_rc == SCMF_RC_INVALID);
  assign stat_idx = i_rx_tag[SCMF_TBL_AW-1:0];
  assign fail_idx = i_fail_tag[SCMF_TBL_AW-1:0];

  // Table is indexed by low tag bits; tags must be unique modulo the depth.
  genvar g;
  generate
    for (g = 0; g < SCMF_TBL_DEPTH; g++) begin : g_tbl
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          tbl_dest_r[g]  <= 64'h0;
          tbl_lun_r[g]   <= 8'h0;
          tbl_dibuf_r[g] <= 32'h0;
        end else if (i_tbl_wr && i_tbl_tag[SCMF_TBL_AW-1:0] == SCMF_TBL_AW'(g)) begin
          tbl_dest_r[g]  <= i_tbl_dest;
          tbl_lun_r[g]   <= i_tbl_lun;
          tbl_dibuf_r[g] <= i_tbl_dibuf;
        end
      end
    end
  endgenerate

  // Command path: hold fields while the unique ID lookup runs.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cmd_st_r   <= SCMF_CMD_IDLE;
      o_uid_req  <= 1'b0;
      o_uid_rpid <= 8'h0;
      o_cmd_ind  <= 1'b0;
      o_cmd_src  <= 64'h0;
      o_cmd_tag  <= 16'h0;
      o_cmd_lun  <= 8'h0;
      o_cmd_attr <= 2'h0;
      o_cmd_cdb  <= 128'h0;
    end else begin
      o_cmd_ind <= 1'b0;
      case (cmd_st_r)
        SCMF_CMD_IDLE: begin
          if (is_cmd) begin
            o_uid_req  <= 1'b1;
            o_uid_rpid <= i_rx_rpid;  // see R2
            o_cmd_tag  <= i_rx_tag;
            o_cmd_lun  <= i_rx_lun;
            o_cmd_attr <= i_rx_qcntl;
            o_cmd_cdb  <= i_rx_cdb;
            cmd_st_r   <= SCMF_CMD_WAIT;
          end
        end
        SCMF_CMD_WAIT: begin
          if (i_uid_ack) begin
            o_uid_req <= 1'b0;
            o_cmd_src <= i_uid_val;  // see R2
            o_cmd_ind <= 1'b1;  // see R1
            cmd_st_r  <= SCMF_CMD_IDLE;
          end
        end
        default: cmd_st_r <= SCMF_CMD_IDLE;
      endcase
    end
  end

  // Status build and send.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_tx_send     <= 1'b0;
      o_tx_ctrl     <= 8'h0;
      o_tx_dest     <= 64'h0;
      o_tx_len      <= 8'h0;
      o_tx_sms_code <= 8'h0;
      o_tx_s3p_code <= 8'h0;
      o_tx_tag      <= 16'h0;
      o_tx_status   <= 8'h0;
      o_tx_flag     <= 1'b0;
      o_tx_link     <= 1'b0;
    end else begin
      o_tx_send <= i_cc_req;
      if (i_cc_req) begin
        o_tx_sms_code <= SCMF_SMS_CODE;  // see R3
        o_tx_s3p_code <= SCMF_S3P_CMD_STAT;  // see R3
        o_tx_tag      <= i_cc_tag;  // see R4
        o_tx_status   <= i_cc_status;  // see R4
        o_tx_flag     <= (i_cc_resp == SCMF_SR_LINKED_FLAG);  // see R5
        o_tx_link     <= (i_cc_resp == SCMF_SR_LINKED) || (i_cc_resp == SCMF_SR_LINKED_FLAG);  // see R5
        o_tx_ctrl     <= SCMF_SEND_CTRL;  // see R6
        o_tx_dest     <= i_cc_dest;  // see R6
        o_tx_len      <= SCMF_SMS_LEN;  // see R6
      end
    end
  end

  // Completions; a received status takes priority over a same-cycle failure.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_cpl_ind    <= 1'b0;
      o_cpl_dest   <= 64'h0;
      o_cpl_src    <= 64'h0;
      o_cpl_tag    <= 16'h0;
      o_cpl_lun    <= 8'h0;
      o_cpl_dibuf  <= 32'h0;
      o_cpl_status <= 8'h0;
      o_cpl_resp   <= 2'h0;
    end else begin
      o_cpl_ind <= is_stat || fail_hit;  // see R9
      if (is_stat) begin
        o_cpl_tag    <= i_rx_tag;  // see R7
        o_cpl_dest   <= tbl_dest_r[stat_idx];  // see R7
        o_cpl_lun    <= tbl_lun_r[stat_idx];
        o_cpl_dibuf  <= tbl_dibuf_r[stat_idx];
        o_cpl_status <= i_rx_status;  // see R8
        o_cpl_resp   <= SCMF_SR_TASK_COMPLETE;  // see R8
        o_cpl_src    <= i_own_uid;  // see R12
      end else if (fail_hit) begin
        o_cpl_tag    <= i_fail_tag;  // see R10
        o_cpl_dest   <= tbl_dest_r[fail_idx];  // see R10
        o_cpl_lun    <= tbl_lun_r[fail_idx];
        o_cpl_dibuf  <= 32'h0;
        o_cpl_status <= 8'h0;
        o_cpl_resp   <= SCMF_SR_DELIV_FAIL;  // see R11
        o_cpl_src    <= i_own_uid;  // see R12
      end
    end
  end

  // Data-In mapping onto target read; data ready messages follow from transport.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_tr_req    <= 1'b0;
      o_tr_dest   <= 64'h0;
      o_tr_tag    <= 16'h0;
      o_tr_buf    <= 32'h0;
      o_tr_offset <= 32'h0;
      o_tr_count  <= 32'h0;
      o_tr_start  <= 32'h0;
      o_tr_thresh <= 32'h0;
      o_tc_ind    <= 1'b0;
      o_tc_resp   <= 2'h0;
    end else begin
      o_tr_req <= i_di_req;  // see R13
      if (i_di_req) begin
        o_tr_dest   <= i_di_dest;  // see R13
        o_tr_tag    <= i_di_tag;  // see R13
        o_tr_buf    <= i_di_buf;  // see R13
        o_tr_offset <= i_di_offset;  // see R13
        o_tr_count  <= i_di_count;  // see R13
        o_tr_start  <= i_di_count;  // see R14
        o_tr_thresh <= 32'h0;  // see R14
      end
      o_tc_ind <= i_tr_done && (i_tr_rc == SCMF_RC_FAILED);  // see R15
      if (i_tr_done && i_tr_rc == SCMF_RC_FAILED) begin
        o_tc_resp <= SCMF_SR_DELIV_FAIL;  // see R15
      end
    end
  end

  status_codes_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_cc_req |=> o_tx_send && o_tx_sms_code == 8'h83 && o_tx_s3p_code == 8'h10)  // see R3
    else $error("status codes wrong");
  flag_link_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_cc_req |=> o_tx_flag == ($past(i_cc_resp) == 2'h2) &&
      o_tx_link == ($past(i_cc_resp) == 2'h1 || $past(i_cc_resp) == 2'h2))  // see R5
    else $error("flag link encoding wrong");
  send_ctrl_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_cc_req |=> o_tx_ctrl == 8'h00 && o_tx_dest == $past(i_cc_dest))  // see R6
    else $error("send parameters wrong");
  cmd_ind_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_cmd_ind |-> $past(cmd_st_r == SCMF_CMD_WAIT) && $past(i_uid_ack))  // see R1
    else $error("command indication without lookup");
  stat_cpl_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    is_stat |=> o_cpl_ind && o_cpl_resp == 2'h0 && o_cpl_status == $past(i_rx_status))  // see R8
    else $error("status completion wrong");
  fail_cpl_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    fail_hit && !is_stat |=> o_cpl_ind && o_cpl_resp == 2'h3 && o_cpl_tag == $past(i_fail_tag))  // see R11
    else $error("failure completion wrong");
  src_uid_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (is_stat || fail_hit) |=> o_cpl_src == $past(i_own_uid))  // see R12
    else $error("completion source wrong");
  no_bad_cpl_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !is_stat && !fail_hit |=> !o_cpl_ind)  // see R19
    else $error("completion without cause");
  tread_map_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_di_req |=> o_tr_req && o_tr_start == $past(i_di_count) && o_tr_thresh == 32'h0)  // see R14
    else $error("target read defaults wrong");
  tr_fail_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_tr_done && i_tr_rc == 2'h1 |=> o_tc_ind && o_tc_resp == 2'h3)  // see R15
    else $error("target read failure missed");

  cmd_seen_c: cover property (@(posedge i_mclk) disable iff (i_rst) o_cmd_ind);
  status_sent_c: cover property (@(posedge i_mclk) disable iff (i_rst) o_tx_send && o_tx_link);
  fail_cpl_c: cover property (@(posedge i_mclk) disable iff (i_rst) o_cpl_ind && o_cpl_resp == 2'h3);
  tread_c: cover property (@(posedge i_mclk) disable iff (i_rst) o_tr_req);
endmodule
`default_nettype wire

/* File: tb/scmf_xport_model.sv */
// Transport model that answers unique ID lookups for the framer.
`timescale 1ns/1ps
`default_nettype none
module scmf_xport_model (
  input  wire logic        i_mclk,
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_uid_req,
  input  wire logic [7:0]  i_uid_rpid,
  output logic             o_uid_ack,
  output logic [63:0]      o_uid_val
);
  logic [3:0] wait_r;
  initial begin
    o_uid_ack = 1'b0;
    o_uid_val = 64'h0;
    wait_r    = 4'h0;
  end
  // The answer is only valid with the ack, so the value toggles otherwise to expose stale use.
  always @(negedge i_mclk) begin
    if (o_uid_ack) begin
      o_uid_ack <= 1'b0;
      o_uid_val <= ~o_uid_val;
    end else if (i_uid_req && wait_r == i_delay) begin
      o_uid_ack <= 1'b1;
      o_uid_val <= {56'h5a5a_0000_1234_00, i_uid_rpid};
      wait_r    <= 4'h0;
    end else begin
      wait_r    <= i_uid_req ? wait_r + 4'h1 : 4'h0;
      o_uid_val <= ~o_uid_val;
    end
  end
endmodule
`default_nettype wire

/* File: tb/scsi_cmd_status_msg_framer_tb.sv */
// Self-checking testbench for the command, status and Data-In framer.
`timescale 1ns/1ps
`default_nettype none
module scsi_cmd_status_msg_framer_tb;
  import scmf_pkg::*;
  localparam logic [63:0] OWN_UID = 64'h0123_4567_89ab_cdef;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_rx_valid = 1'b0, i_cc_req = 1'b0, i_tbl_wr = 1'b0;
  logic i_fail_valid = 1'b0, i_di_req = 1'b0, i_tr_done = 1'b0, i_uid_ack;
  logic [63:0] i_own_uid = OWN_UID, i_cc_dest = '0, i_tbl_dest = '0, i_di_dest = '0, i_uid_val;
  logic [7:0] i_rx_sms_code = '0, i_rx_s3p_code = '0, i_rx_lun = '0, i_rx_status = '0;
  logic [7:0] i_rx_rpid = '0, i_cc_status = '0, i_tbl_lun = '0;
  logic [15:0] i_rx_tag = '0, i_cc_tag = '0, i_tbl_tag = '0, i_fail_tag = '0, i_di_tag = '0;
  logic [1:0] i_rx_qcntl = '0, i_cc_resp = '0, i_fail_rc = '0, i_tr_rc = '0;
  logic [127:0] i_rx_cdb = '0, o_cmd_cdb;
  logic [31:0] i_tbl_dibuf = '0, i_di_buf = '0, i_di_offset = '0, i_di_count = '0;
  logic o_uid_req, o_cmd_ind, o_tx_send, o_tx_flag, o_tx_link, o_cpl_ind, o_tr_req, o_tc_ind;
  logic [7:0] o_uid_rpid, o_cmd_lun, o_tx_ctrl, o_tx_len, o_tx_sms_code, o_tx_s3p_code;
  logic [7:0] o_tx_status, o_cpl_lun, o_cpl_status;
  logic [63:0] o_cmd_src, o_tx_dest, o_cpl_dest, o_cpl_src, o_tr_dest;
  logic [15:0] o_cmd_tag, o_tx_tag, o_cpl_tag, o_tr_tag;
  logic [1:0] o_cmd_attr, o_cpl_resp, o_tc_resp;
  logic [31:0] o_cpl_dibuf, o_tr_buf, o_tr_offset, o_tr_count, o_tr_start, o_tr_thresh;
  logic [3:0] uid_delay = 4'h0;
  int n_errors = 0;
  int cmp_count = 0;

  scmf_framer dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_own_uid(i_own_uid), .i_rx_valid(i_rx_valid),
    .i_rx_sms_code(i_rx_sms_code), .i_rx_s3p_code(i_rx_s3p_code), .i_rx_tag(i_rx_tag),
    .i_rx_lun(i_rx_lun), .i_rx_qcntl(i_rx_qcntl), .i_rx_status(i_rx_status),
    .i_rx_rpid(i_rx_rpid), .i_rx_cdb(i_rx_cdb), .i_uid_ack(i_uid_ack), .i_uid_val(i_uid_val),
    .i_cc_req(i_cc_req), .i_cc_dest(i_cc_dest), .i_cc_tag(i_cc_tag),
    .i_cc_status(i_cc_status), .i_cc_resp(i_cc_resp), .i_tbl_wr(i_tbl_wr),
    .i_tbl_tag(i_tbl_tag), .i_tbl_dest(i_tbl_dest), .i_tbl_lun(i_tbl_lun),
    .i_tbl_dibuf(i_tbl_dibuf), .i_fail_valid(i_fail_valid), .i_fail_rc(i_fail_rc),
    .i_fail_tag(i_fail_tag), .i_di_req(i_di_req), .i_di_dest(i_di_dest), .i_di_tag(i_di_tag),
    .i_di_buf(i_di_buf), .i_di_offset(i_di_offset), .i_di_count(i_di_count),
    .i_tr_done(i_tr_done), .i_tr_rc(i_tr_rc), .o_uid_req(o_uid_req), .o_uid_rpid(o_uid_rpid),
    .o_cmd_ind(o_cmd_ind), .o_cmd_src(o_cmd_src), .o_cmd_tag(o_cmd_tag),
    .o_cmd_lun(o_cmd_lun), .o_cmd_attr(o_cmd_attr), .o_cmd_cdb(o_cmd_cdb),
    .o_tx_send(o_tx_send), .o_tx_ctrl(o_tx_ctrl), .o_tx_dest(o_tx_dest), .o_tx_len(o_tx_len),
    .o_tx_sms_code(o_tx_sms_code), .o_tx_s3p_code(o_tx_s3p_code), .o_tx_tag(o_tx_tag),
    .o_tx_status(o_tx_status), .o_tx_flag(o_tx_flag), .o_tx_link(o_tx_link),
    .o_cpl_ind(o_cpl_ind), .o_cpl_dest(o_cpl_dest), .o_cpl_src(o_cpl_src),
    .o_cpl_tag(o_cpl_tag), .o_cpl_lun(o_cpl_lun), .o_cpl_dibuf(o_cpl_dibuf),
    .o_cpl_status(o_cpl_status), .o_cpl_resp(o_cpl_resp), .o_tr_req(o_tr_req),
    .o_tr_dest(o_tr_dest), .o_tr_tag(o_tr_tag), .o_tr_buf(o_tr_buf),
    .o_tr_offset(o_tr_offset), .o_tr_count(o_tr_count), .o_tr_start(o_tr_start),
    .o_tr_thresh(o_tr_thresh), .o_tc_ind(o_tc_ind), .o_tc_resp(o_tc_resp));
  scmf_xport_model xport (.i_mclk(i_mclk), .i_delay(uid_delay), .i_uid_req(o_uid_req),
    .i_uid_rpid(o_uid_rpid), .o_uid_ack(i_uid_ack), .o_uid_val(i_uid_val));

  always #10 i_mclk = ~i_mclk;

  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic rx_msg(input logic [7:0] sc, input logic [7:0] pc, input logic [127:0] cdb);
    i_rx_sms_code = sc;
    i_rx_s3p_code = pc;
    i_rx_cdb      = cdb;
    i_rx_valid    = 1'b1;
    tick(1);
    i_rx_valid    = 1'b0;
  endtask

  // A slow lookup must still deliver the ID that belongs to the return path.
  task automatic t_cmd(input logic [7:0] rp, input logic [3:0] dly);
    int k;
    uid_delay = dly;
    i_rx_tag = {8'h3c, rp};
    i_rx_lun = rp ^ 8'h11;
    i_rx_qcntl = rp[1:0];
    i_rx_rpid = rp;
    rx_msg(SCMF_SMS_CODE, SCMF_S3P_CMD_STAT, {16{rp ^ 8'h5e}});
    chk({o_uid_req, o_uid_rpid}, {1'b1, rp});
    k = 0;
    while (o_cmd_ind !== 1'b1) begin
      tick(1);
      k++;
      if (k == 30) begin
        n_errors++;
        tally_and_finish();
      end
    end
    chk(o_cmd_src, {56'h5a5a_0000_1234_00, rp});
    chk({o_cmd_tag, o_cmd_lun, o_cmd_attr}, {8'h3c, rp, rp ^ 8'h11, rp[1:0]});
    chk(o_cmd_cdb, {16{rp ^ 8'h5e}});
  endtask

  // Back-to-back completions, one per service response code.
  task automatic t_status();
    for (int i = 0; i < 5; i++) begin
      i_cc_req = (i < 4);
      i_cc_dest = 64'hd0 + i;
      i_cc_tag = 16'h100 + i;
      i_cc_status = 8'h02 << i;
      i_cc_resp = i[1:0];
      tick(1);
      chk(o_tx_send, i < 4);
      if (i < 4) begin
        chk({o_tx_sms_code, o_tx_s3p_code}, 16'h8310);
        chk({o_tx_tag, o_tx_status}, {16'(16'h100 + i), 8'h02 << i});
        chk({o_tx_flag, o_tx_link}, i == 2 ? 2'h3 : (i == 1 ? 2'h1 : 2'h0));
        chk({o_tx_ctrl, o_tx_dest, o_tx_len}, {8'h00, 64'hd0 + i, SCMF_SMS_LEN});
      end
    end
  endtask

  task automatic t_cpl();
    i_tbl_wr = 1'b1;
    i_tbl_tag = 16'h0025;
    i_tbl_dest = 64'hdd05;
    i_tbl_lun = 8'h45;
    i_tbl_dibuf = 32'hb000_0500;
    tick(1);
    i_tbl_wr = 1'b0;
    i_rx_tag = 16'h0025;
    i_rx_status = 8'h08;
    rx_msg(SCMF_SMS_CODE, SCMF_S3P_CMD_STAT, '0);
    chk({o_cpl_ind, o_cpl_tag, o_cpl_dest}, {1'b1, 16'h0025, 64'hdd05});
    chk({o_cpl_lun, o_cpl_dibuf}, {8'h45, 32'hb000_0500});
    chk({o_cpl_status, o_cpl_resp}, {8'h08, SCMF_SR_TASK_COMPLETE});
    chk(o_cpl_src, OWN_UID);
    // Return codes ok, failed, invalid in consecutive cycles.
    for (int i = 0; i < 4; i++) begin
      i_fail_valid = (i < 3);
      i_fail_rc = i[1:0];
      i_fail_tag = 16'h0025;
      tick(1);
      chk(o_cpl_ind, i == 1 || i == 2);
      if (i == 1 || i == 2) begin
        chk({o_cpl_tag, o_cpl_dest, o_cpl_lun}, {16'h0025, 64'hdd05, 8'h45});
        chk(o_cpl_resp, SCMF_SR_DELIV_FAIL);
        chk(o_cpl_src, OWN_UID);
      end
    end
  endtask

  // A wrong code in either field must be dropped silently.
  task automatic t_bad();
    for (int i = 0; i < 2; i++) begin
      rx_msg(i ? 8'h83 : 8'h84, i ? 8'h11 : 8'h10, i ? 128'h0 : 128'h1);
      repeat (3) begin
        chk({o_uid_req, o_cmd_ind, o_cpl_ind}, 3'h0);
        tick(1);
      end
    end
  endtask

  task automatic t_di();
    i_di_req = 1'b1;
    i_di_dest = 64'hdead_0001;
    i_di_tag = 16'h0042;
    i_di_buf = 32'h8000_1000;
    i_di_offset = 32'h40;
    i_di_count = 32'h200;
    tick(1);
    chk({o_tr_req, o_tr_dest, o_tr_tag}, {1'b1, 64'hdead_0001, 16'h0042});
    chk({o_tr_buf, o_tr_offset, o_tr_count}, {32'h8000_1000, 32'h40, 32'h200});
    chk({o_tr_start, o_tr_thresh}, {32'h200, 32'h0});
    i_di_req = 1'b0;
    i_tr_done = 1'b1;
    i_tr_rc = SCMF_RC_FAILED;
    tick(1);
    chk({o_tc_ind, o_tc_resp}, {1'b1, SCMF_SR_DELIV_FAIL});
    i_tr_rc = SCMF_RC_OK;
    tick(1);
    chk(o_tc_ind, 1'b0);
    i_tr_done = 1'b0;
  endtask

  initial begin
    tick(16);
    i_rst = 1'b0;
    tick(1);
    t_cmd(8'h07, 4'h0);
    t_cmd(8'hc3, 4'h5);
    t_status();
    t_cpl();
    t_bad();
    t_di();
    tick(2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
